// [hdl/ppm_pkg.sv]
// shared constants, register map and state types of the port power manager
package ppm_pkg;
  localparam int          NCH           = 12;          // channels
  localparam int          NPAIR         = 4;           // boost pairs, slave = master + NPAIR
  localparam int          CLK_HZ        = 125_000_000;
  localparam int          CLS_STD_MS    = 15;          // standard classification pulse, ms
  localparam int          CLS_BOOST_MS  = 70;          // whole boost classification, ms
  localparam int          BOOST_PULSES  = 3;
  // temperature reading in whole degrees C
  localparam logic [7:0]  T_WARN        = 8'h6E;       // 110 C
  localparam logic [7:0]  T_HOT         = 8'h82;       // 130 C
  localparam logic [7:0]  T_CRIT        = 8'h96;       // 150 C
  localparam logic [7:0]  T_REL         = 8'h64;       // 100 C
  // load power categories and allowances in mW
  localparam logic [2:0]  CAT_STD_MAX   = 3'h4;
  localparam logic [2:0]  CAT_BOOST     = 3'h5;
  localparam logic [15:0] ALLOW_C0      = 16'h3C28;    // 15400 mW
  localparam logic [15:0] ALLOW_C1      = 16'h0FA0;    // 4000 mW
  localparam logic [15:0] ALLOW_C2      = 16'h1B58;    // 7000 mW
  localparam logic [15:0] ALLOW_C3      = 16'h3C28;
  localparam logic [15:0] ALLOW_C4      = 16'h3C28;
  localparam logic [15:0] ALLOW_BOOST   = 16'h7530;    // 30000 mW
  // signature resistance in 10 ohm units
  localparam logic [15:0] RES_BASE      = 16'h0320;    // 8.00 kohm = code 0
  localparam logic [15:0] RES_OPEN      = 16'hC350;    // 500 kohm
  localparam logic [15:0] RES_CODE_MAX  = 16'h0FFF;
  // register map (word addresses)
  localparam logic [7:0]  A_CTRL        = 8'h00;
  localparam logic [7:0]  A_BUDGET      = 8'h01;
  localparam logic [7:0]  A_USED        = 8'h02;
  localparam logic [7:0]  A_STAT        = 8'h03;
  localparam logic [7:0]  A_PWR         = 8'h04;
  localparam logic [7:0]  A_ALARM       = 8'h05;
  localparam logic [7:0]  A_OPEN        = 8'h06;
  localparam logic [7:0]  A_MANUAL      = 8'h07;
  localparam logic [3:0]  R_PRIO        = 4'h1;        // 0x10 + channel
  localparam logic [3:0]  R_IMON        = 4'h2;        // 0x20 + channel
  localparam logic [3:0]  R_VMEAS       = 4'h3;        // 0x30 + channel
  localparam logic [3:0]  R_SIG         = 4'h4;        // 0x40 + channel
  // control register fields
  localparam int          B_AUTO        = 0;
  localparam int          B_SMART       = 1;
  localparam int          B_BOOST       = 2;
  localparam int          B_WARN_DIS    = 3;
  localparam int          B_HOT_DIS     = 4;
  localparam int          B_RES_CODE    = 5;
  localparam int          B_PRIO_HOLD   = 6;
  localparam int          B_OVLD_CUT    = 7;
  localparam logic [7:0]  CTRL_RST      = 8'hC1;
  localparam logic [15:0] BUDGET_RST    = 16'hFFFF;
  localparam logic [1:0]  K_VOLT        = 2'h0;
  localparam logic [1:0]  K_CUR         = 2'h1;

  typedef enum logic [1:0] {TH_NORM = 2'b00, TH_WARN = 2'b01, TH_HOT = 2'b11, TH_CRIT = 2'b10} ppm_therm_t;
  typedef enum logic [1:0] {CL_IDLE = 2'b00, CL_PULSE = 2'b01, CL_GAP = 2'b11} ppm_cls_t;
endpackage

// [hdl/ppm_port_power_manager.sv]
// port power manager: thermal gating, smart-power admission, boost pairing, measurement coding
// Summary of operation
// - at 110C stop admitting new channels until 100C
// - at 130C drop limiting channels, optional disable
// - at 150C drop all channels, no disable
// - smart mode admits only within power budget
// - per-channel priority, highest admitted first
// - optionally hold lower priorities while power short
// - overconsuming channel cut, allowance returned to budget
// - 12-bit voltage and signature, 15-bit current measurements stored in readable registers
// - boost class powers a parallel channel pair
// - pairs are 1-5, 2-6, 3-7, 4-8
// - boost skips slave detection, classes 0-4 single
// - fault on either pair member drops both
// - pair power, measurements and signature report only in master registers
// - boost classification three pulses, 70 ms total
// - powered current coded in 32768 fine steps
// - conductance coding default, resistance selectable
// - open-circuit flag above 500 kohm
// - autonomous or host-driven manual operation
// - overload cut after timer and average exceed
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module ppm_port_power_manager
  import ppm_pkg::*;
#(
  parameter int CLS_STD_CYC  = CLS_STD_MS * (CLK_HZ / 1000),
  parameter int BOOST_HALF   = CLS_BOOST_MS * (CLK_HZ / 1000) / (2 * BOOST_PULSES)
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire logic [7:0]        addr_i,
  input  wire logic [15:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [15:0]       rd_data_o,
  input  wire logic [7:0]        temp_i,
  input  wire logic              temp_valid_i,
  input  wire logic              det_ok_i,
  input  wire logic [3:0]        det_chan_i,
  input  wire logic              cls_valid_i,
  input  wire logic [3:0]        cls_chan_i,
  input  wire logic [2:0]        load_power_category_i,
  input  wire logic [NCH-1:0]    ilim_i,
  input  wire logic [NCH-1:0]    fault_i,
  input  wire logic [NCH-1:0]    ovld_exp_i,
  input  wire logic [NCH-1:0]    pwr_over_i,
  input  wire logic              adc_valid_i,
  input  wire logic [3:0]        adc_chan_i,
  input  wire logic [1:0]        adc_kind_i,
  input  wire logic [14:0]       adc_data_i,
  input  wire logic              sig_valid_i,
  input  wire logic [3:0]        sig_chan_i,
  input  wire logic [9:0]        sig_cond_i,
  input  wire logic [15:0]       sig_res_i,
  output logic      [NCH-1:0]    pwr_en_o,
  output logic                   cls_pulse_o,
  output logic      [3:0]        cls_chan_o,
  output logic      [1:0]        therm_o
);

  localparam logic [23:0] STD_LEN   = 24'(CLS_STD_CYC - 1);
  localparam logic [23:0] BOOST_LEN = 24'(BOOST_HALF - 1);

  logic [7:0]     ctrl_r;
  logic [15:0]    budget_r;
  logic [1:0]     prio_r [NCH];
  logic [2:0]     cat_r [NCH];
  logic [14:0]    imon_r [NCH];
  logic [11:0]    vmeas_r [NCH];
  logic [11:0]    sig_r [NCH];
  logic [NCH-1:0] pwr_r;
  logic [NCH-1:0] pend_r;
  logic [NCH-1:0] alarm_r;
  logic [NCH-1:0] open_r;
  logic [NPAIR-1:0] paired_r;
  ppm_therm_t     therm_r;
  ppm_therm_t     therm_nxt;
  ppm_cls_t       cls_st_r;
  logic [23:0]    cls_cnt_r;
  logic [23:0]    cls_len_r;
  logic [1:0]     cls_left_r;
  logic           cls_boost_r;
  logic           cls_pulse_r;
  logic [3:0]     cls_chan_r;
  logic [15:0]    rd_data_r;

  logic           sel_vld;
  logic [3:0]     sel_ch;
  logic [1:0]     sel_best;
  logic           sel_boost;
  logic [15:0]    need;
  logic [19:0]    used;
  logic           fits;
  logic           inrush_busy;
  logic           admit_try;
  logic           grant;
  logic           reject;
  logic           cls_go;
  logic           manual_wr;
  logic [NCH-1:0] ovcut;
  logic [NCH-1:0] off_raw;
  logic [NCH-1:0] off;
  logic [NCH-1:0] on;
  logic [NCH-1:0] in_pair;
  logic [NCH-1:0] slave_hid;
  logic [15:0]    eff_alloc [NCH];
  logic [15:0]    sig_sub;

  function automatic logic [15:0] alloc_f(input logic [2:0] c);
    case (c)
      3'h1:    alloc_f = ALLOW_C1;
      3'h2:    alloc_f = ALLOW_C2;
      3'h3:    alloc_f = ALLOW_C3;
      3'h4:    alloc_f = ALLOW_C4;
      default: alloc_f = ALLOW_C0;
    endcase
  endfunction

  function automatic logic [1:0] rank_f(input ppm_therm_t t);
    case (t)
      TH_WARN: rank_f = 2'h1;
      TH_HOT:  rank_f = 2'h2;
      TH_CRIT: rank_f = 2'h3;
      default: rank_f = 2'h0;
    endcase
  endfunction

  function automatic logic is_slave_f(input logic [3:0] c);
    is_slave_f = (c >= 4'(NPAIR)) && (c < 4'(2 * NPAIR));
  endfunction

  // thermal level: raise on threshold, hold until release temperature
  always_comb begin
    ppm_therm_t raise;
    raise = TH_NORM;
    if (temp_i >= T_CRIT) begin
      raise = TH_CRIT;
    end else if (temp_i >= T_HOT && !ctrl_r[B_HOT_DIS]) begin
      raise = TH_HOT;
    end else if (temp_i >= T_WARN && !ctrl_r[B_WARN_DIS]) begin
      raise = TH_WARN;
    end
    therm_nxt = therm_r;
    if (temp_valid_i) begin
      if (rank_f(raise) > rank_f(therm_r)) begin
        therm_nxt = raise;
      end else if (temp_i <= T_REL) begin
        therm_nxt = TH_NORM;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      therm_r <= TH_NORM;
    end else if (ce_i) begin
      therm_r <= therm_nxt;
    end
  end

  // classification sequencer; slaves skipped in boost mode
  assign cls_go = det_ok_i && (det_chan_i < 4'(NCH)) && !pwr_r[det_chan_i] &&
                  !(ctrl_r[B_BOOST] && is_slave_f(det_chan_i));

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cls_st_r    <= CL_IDLE;
      cls_cnt_r   <= '0;
      cls_len_r   <= '0;
      cls_left_r  <= '0;
      cls_boost_r <= 1'b0;
      cls_pulse_r <= 1'b0;
      cls_chan_r  <= '0;
    end else if (ce_i) begin
      case (cls_st_r)
        CL_IDLE: begin
          if (cls_go) begin
            cls_st_r    <= CL_PULSE;
            cls_pulse_r <= 1'b1;
            cls_chan_r  <= det_chan_i;
            cls_cnt_r   <= '0;
            cls_boost_r <= ctrl_r[B_BOOST];
            cls_left_r  <= ctrl_r[B_BOOST] ? 2'(BOOST_PULSES - 1) : 2'h0;
            cls_len_r   <= ctrl_r[B_BOOST] ? BOOST_LEN : STD_LEN;
          end
        end
        CL_PULSE: begin
          if (cls_cnt_r == cls_len_r) begin
            cls_pulse_r <= 1'b0;
            cls_cnt_r   <= '0;
            // each boost pulse owns a pulse half and a gap half of its slot
            cls_st_r    <= cls_boost_r ? CL_GAP : CL_IDLE;
          end else begin
            cls_cnt_r <= cls_cnt_r + 24'h000001;
          end
        end
        CL_GAP: begin
          if (cls_cnt_r == cls_len_r) begin
            cls_cnt_r <= '0;
            if (cls_left_r == 2'h0) begin
              cls_st_r <= CL_IDLE;
            end else begin
              cls_left_r  <= cls_left_r - 2'h1;
              cls_pulse_r <= 1'b1;
              cls_st_r    <= CL_PULSE;
            end
          end else begin
            cls_cnt_r <= cls_cnt_r + 24'h000001;
          end
        end
        default: cls_st_r <= CL_IDLE;
      endcase
    end
  end

  // priority arbiter: ties go to the lowest channel number
  always_comb begin
    sel_vld  = 1'b0;
    sel_ch   = '0;
    sel_best = '0;
    for (int i = 0; i < NCH; i++) begin
      if (pend_r[i] && (!sel_vld || prio_r[i] > sel_best)) begin
        sel_vld  = 1'b1;
        sel_ch   = 4'(i);
        sel_best = prio_r[i];
      end
    end
  end

  always_comb begin
    used = '0;
    for (int i = 0; i < NCH; i++) begin
      used = used + {4'h0, eff_alloc[i]};
    end
  end

  assign sel_boost   = ctrl_r[B_BOOST] && (cat_r[sel_ch] == CAT_BOOST) && (sel_ch < 4'(NPAIR));
  assign need        = sel_boost ? ALLOW_BOOST : alloc_f(cat_r[sel_ch]);
  assign fits        = !ctrl_r[B_SMART] || (used + {4'h0, need} <= {4'h0, budget_r});
  // one activation at a time: wait until earlier channels leave inrush
  assign inrush_busy = |(ilim_i & pwr_r);
  assign admit_try   = ctrl_r[B_AUTO] && sel_vld && (therm_r == TH_NORM) && !inrush_busy;
  assign grant       = admit_try && fits;
  // with hold set the best candidate stays pending and blocks all lower ones
  assign reject      = admit_try && !fits && !ctrl_r[B_PRIO_HOLD];
  assign manual_wr   = wr_i && (addr_i == A_MANUAL) && !ctrl_r[B_AUTO] && (therm_r == TH_NORM);

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      localparam logic [3:0] CH = 4'(ch);
      if (ch < NPAIR) begin : g_m
        assign in_pair[ch]   = paired_r[ch];
        assign off[ch]       = off_raw[ch] | (paired_r[ch] & off_raw[ch + NPAIR]);
        assign slave_hid[ch] = 1'b0;
        assign on[ch]        = (grant && sel_ch == CH) || (manual_wr && wdata_i[ch]);

        always_ff @(posedge ref_clk_i) begin
          if (!rst_n_i) begin
            paired_r[ch] <= 1'b0;
          end else if (ce_i) begin
            if (off[ch]) begin
              paired_r[ch] <= 1'b0;
            end else if (grant && sel_boost && sel_ch == CH) begin
              paired_r[ch] <= 1'b1;
            end
          end
        end

        a_pair_equal: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
          paired_r[ch] |-> (pwr_r[ch] && pwr_r[ch + NPAIR]))
          else $error("boosted pair members differ in power state");
      end else if (ch < 2 * NPAIR) begin : g_s
        assign in_pair[ch]   = paired_r[ch - NPAIR];
        assign off[ch]       = off_raw[ch] | (paired_r[ch - NPAIR] & off_raw[ch - NPAIR]);
        assign slave_hid[ch] = paired_r[ch - NPAIR];
        assign on[ch]        = (grant && sel_ch == CH) || (manual_wr && wdata_i[ch]) ||
                               (grant && sel_boost && sel_ch == 4'(ch - NPAIR));
      end else begin : g_n
        assign in_pair[ch]   = 1'b0;
        assign off[ch]       = off_raw[ch];
        assign slave_hid[ch] = 1'b0;
        assign on[ch]        = (grant && sel_ch == CH) || (manual_wr && wdata_i[ch]);
      end

      assign ovcut[ch]     = ctrl_r[B_OVLD_CUT] && ovld_exp_i[ch] && pwr_over_i[ch] && pwr_r[ch];
      assign off_raw[ch]   = (therm_r == TH_CRIT) ||
                             ((therm_r == TH_HOT) && ilim_i[ch]) ||
                             (fault_i[ch] && pwr_r[ch]) || ovcut[ch];
      assign eff_alloc[ch] = !pwr_r[ch] || slave_hid[ch] ? 16'h0000 :
                             (in_pair[ch] ? ALLOW_BOOST : alloc_f(cat_r[ch]));

      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          pwr_r[ch] <= 1'b0;
        end else if (ce_i) begin
          if (off[ch]) begin
            pwr_r[ch] <= 1'b0;
          end else if (on[ch]) begin
            pwr_r[ch] <= 1'b1;
          end
        end
      end

      // a new classification wins over a same-cycle grant or reject
      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          pend_r[ch] <= 1'b0;
          cat_r[ch]  <= '0;
        end else if (ce_i) begin
          if (cls_valid_i && cls_chan_i == CH && !(ctrl_r[B_BOOST] && is_slave_f(CH))) begin
            pend_r[ch] <= 1'b1;
            cat_r[ch]  <= load_power_category_i;
          end else if ((grant || reject) && sel_ch == CH) begin
            pend_r[ch] <= 1'b0;
          end
        end
      end

      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          alarm_r[ch] <= 1'b0;
        end else if (ce_i) begin
          if (ovcut[ch] || (fault_i[ch] && pwr_r[ch]) || (reject && sel_ch == CH)) begin
            alarm_r[ch] <= 1'b1;
          end else if (wr_i && addr_i == A_ALARM && wdata_i[ch]) begin
            alarm_r[ch] <= 1'b0;
          end
        end
      end

      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          imon_r[ch]  <= '0;
          vmeas_r[ch] <= '0;
        end else if (ce_i && adc_valid_i && adc_chan_i == CH && !slave_hid[ch]) begin
          if (adc_kind_i == K_CUR) begin
            imon_r[ch] <= adc_data_i;
          end else if (adc_kind_i == K_VOLT) begin
            vmeas_r[ch] <= adc_data_i[11:0];
          end
        end
      end

      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          sig_r[ch]  <= '0;
          open_r[ch] <= 1'b0;
        end else if (ce_i && sig_valid_i && sig_chan_i == CH && !slave_hid[ch]) begin
          open_r[ch] <= (sig_sub > RES_OPEN - RES_BASE) && (sig_res_i > RES_BASE);
          if (!ctrl_r[B_RES_CODE]) begin
            sig_r[ch] <= {2'h0, sig_cond_i};
          end else if (sig_res_i <= RES_BASE) begin
            sig_r[ch] <= '0;
          end else begin
            sig_r[ch] <= sig_sub > RES_CODE_MAX ? RES_CODE_MAX[11:0] : sig_sub[11:0];
          end
        end
      end

      a_ovld_cut_alarm: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (ce_i && ctrl_r[B_OVLD_CUT] && pwr_r[ch] && ovld_exp_i[ch] && pwr_over_i[ch]) |=> (!pwr_r[ch] && alarm_r[ch]))
        else $error("overload did not cut power and raise alarm");
    end
  endgenerate

  assign sig_sub = sig_res_i - RES_BASE;

  // register file
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl_r   <= CTRL_RST;
      budget_r <= BUDGET_RST;
    end else if (ce_i && wr_i) begin
      if (addr_i == A_CTRL) begin
        ctrl_r <= wdata_i[7:0];
      end
      if (addr_i == A_BUDGET) begin
        budget_r <= wdata_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NCH; i++) begin
        prio_r[i] <= '0;
      end
    end else if (ce_i && wr_i && addr_i[7:4] == R_PRIO && addr_i[3:0] < 4'(NCH)) begin
      prio_r[addr_i[3:0]] <= wdata_i[1:0];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rd_data_r <= '0;
    end else if (ce_i) begin
      rd_data_r <= '0;
      if (rd_i) begin
        case (addr_i)
          A_CTRL:   rd_data_r <= {8'h00, ctrl_r};
          A_BUDGET: rd_data_r <= budget_r;
          A_USED:   rd_data_r <= used[15:0];
          A_STAT:   rd_data_r <= {14'h0000, therm_r};
          A_PWR:    rd_data_r <= {4'h0, pwr_r & ~slave_hid};
          A_ALARM:  rd_data_r <= {4'h0, alarm_r};
          A_OPEN:   rd_data_r <= {4'h0, open_r};
          default: begin
            if (addr_i[3:0] < 4'(NCH)) begin
              case (addr_i[7:4])
                R_PRIO:  rd_data_r <= {14'h0000, prio_r[addr_i[3:0]]};
                R_IMON:  rd_data_r <= {1'b0, imon_r[addr_i[3:0]]};
                R_VMEAS: rd_data_r <= {4'h0, vmeas_r[addr_i[3:0]]};
                R_SIG:   rd_data_r <= {4'h0, sig_r[addr_i[3:0]]};
                default: rd_data_r <= '0;
              endcase
            end
          end
        endcase
      end
    end
  end

  assign rd_data_o   = rd_data_r;
  assign pwr_en_o    = pwr_r;
  assign cls_pulse_o = cls_pulse_r;
  assign cls_chan_o  = cls_chan_r;
  assign therm_o     = therm_r;

  a_crit_all_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ce_i && therm_r == TH_CRIT) |=> (pwr_r == '0))
    else $error("channel still powered at critical temperature");

  a_warm_no_new: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ce_i && therm_r != TH_NORM) |=> ((pwr_r & ~$past(pwr_r)) == '0))
    else $error("channel powered while thermally blocked");

  a_hot_ilim_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ce_i && therm_r == TH_HOT) |=> ((pwr_r & $past(ilim_i)) == '0))
    else $error("limiting channel kept at hot level");

  a_thermal_release: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ce_i && temp_valid_i && temp_i <= T_REL) |=> (therm_r == TH_NORM))
    else $error("thermal level not released at release temperature");

  a_budget_held: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ce_i && grant && ctrl_r[B_SMART]) |=> (pwr_r[$past(sel_ch)] && $past(used) + $past(need) <= $past(budget_r)))
    else $error("admission beyond power budget");

  a_slave_no_cls: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ce_i && cls_st_r == CL_IDLE && det_ok_i && ctrl_r[B_BOOST] && is_slave_f(det_chan_i)) |=> (cls_st_r == CL_IDLE))
    else $error("classification started on slave channel");

  a_cls_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ce_i && cls_st_r == CL_IDLE && cls_go) |=> (cls_pulse_r && cls_chan_r == $past(det_chan_i)
      && cls_left_r == ($past(ctrl_r[B_BOOST]) ? 2'h2 : 2'h0)))
    else $error("classification pulse not started correctly");

  a_open_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ce_i && sig_valid_i && sig_chan_i < 4'(NCH) && !slave_hid[sig_chan_i] && sig_res_i > RES_OPEN)
      |=> open_r[$past(sig_chan_i)])
    else $error("open-circuit flag not raised");

endmodule

// [sim/ppm_pd_model.sv]
// powered-device model: answers detection, reports its class after the probe pulses
`timescale 1ns/1ps
module ppm_pd_model (
  input  wire logic       clk_i,
  input  wire logic       plug_i,
  input  wire logic [3:0] chan_i,
  input  wire logic [2:0] cat_i,
  input  wire logic       cls_pulse_i,
  output logic            det_ok_o = 1'b0,
  output logic [3:0]      det_chan_o = 4'h0,
  output logic            cls_valid_o = 1'b0,
  output logic [3:0]      cls_chan_o = 4'h0,
  output logic [2:0]      cat_o = 3'h0
);
  int q;
  always @(posedge clk_i) begin
    if (plug_i) begin
      {det_ok_o, det_chan_o} <= {1'b1, chan_i};
      @(posedge clk_i) {det_ok_o, det_chan_o} <= {1'b0, ~chan_i};
      q = 0;
      // a gap longer than the boost low phase marks the end of probing
      for (int n = 0; n < 400 && q < 12; n++) begin
        @(posedge clk_i);
        q = cls_pulse_i ? 0 : q + 1;
      end
      {cls_valid_o, cls_chan_o, cat_o} <= {1'b1, chan_i, cat_i};
      // released lines show the inverse, never a stale value
      @(posedge clk_i) {cls_valid_o, cls_chan_o, cat_o} <= {1'b0, ~chan_i, ~cat_i};
    end
  end
endmodule

// [sim/tb_top.sv]
// self-checking bench of the port power manager
`timescale 1ns/1ps
module tb_top;
  import ppm_pkg::*;
  localparam int STD = 20;
  localparam int HALF = 10;
  logic           clk = 0, rst_n = 0, we = 0, re = 0, tv = 0, plug = 0, av = 0, sv = 0;
  logic [7:0]     a = 0, temp = 0;
  logic [15:0]    wd = 0, sres = 0, rdat, used = 0, r;
  logic [NCH-1:0] ilim = 0, flt = 0, ovx = 0, pov = 0, pwr;
  logic [14:0]    ad = 0;
  logic [9:0]     scond = 0;
  logic [3:0]     ach = 0, sch = 0, pch = 0, ch, dch, cch;
  logic [2:0]     pcat = 0, cat;
  logic [1:0]     ak = 0, therm;
  logic           dok, cv, clsp, clsp_q = 0, boost = 0, ce = 1;
  int             miscompares = 0, cmp_count = 0, hi = 0, rises = 0;

  always #4 clk = ~clk;

  ppm_port_power_manager #(.CLS_STD_CYC(STD), .BOOST_HALF(HALF)) ppm_port_power_manager_inst (
    .ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .addr_i(a), .wdata_i(wd), .wr_i(we), .rd_i(re),
    .rd_data_o(rdat), .temp_i(temp), .temp_valid_i(tv), .det_ok_i(dok), .det_chan_i(dch),
    .cls_valid_i(cv), .cls_chan_i(cch), .load_power_category_i(cat), .ilim_i(ilim), .fault_i(flt),
    .ovld_exp_i(ovx), .pwr_over_i(pov), .adc_valid_i(av), .adc_chan_i(ach), .adc_kind_i(ak),
    .adc_data_i(ad), .sig_valid_i(sv), .sig_chan_i(sch), .sig_cond_i(scond), .sig_res_i(sres),
    .pwr_en_o(pwr), .cls_pulse_o(clsp), .cls_chan_o(), .therm_o(therm));

  ppm_pd_model ppm_pd_model_inst (.clk_i(clk), .plug_i(plug), .chan_i(pch), .cat_i(pcat),
    .cls_pulse_i(clsp), .det_ok_o(dok), .det_chan_o(dch), .cls_valid_o(cv), .cls_chan_o(cch), .cat_o(cat));

  always @(posedge clk) begin
    hi += int'(clsp);
    rises += int'(clsp & ~clsp_q);
    clsp_q = clsp;
  end

  function automatic logic [15:0] allow(input logic [2:0] c);
    case (c)
      3'h1: return ALLOW_C1;
      3'h2: return ALLOW_C2;
      3'h5: return ALLOW_BOOST;
      default: return ALLOW_C0;
    endcase
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bw(input logic [7:0] ad_, input logic [15:0] d);
    @(posedge clk) {a, wd, we} <= {ad_, d, 1'b1};
    @(posedge clk) we <= 1'b0;
  endtask

  task automatic br(input logic [7:0] ad_, input logic [15:0] e);
    @(posedge clk) {a, re} <= {ad_, 1'b1};
    @(posedge clk) re <= 1'b0;
    #1 chk(rdat, e);
  endtask

  task automatic tmp(input logic [7:0] t);
    @(posedge clk) {temp, tv} <= {t, 1'b1};
    @(posedge clk) tv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic pd(input logic [3:0] c, input logic [2:0] k);
    // a boosted slave is never probed
    logic sl;
    sl = boost && c >= 4'(NPAIR) && c < 4'(2 * NPAIR);
    hi = 0;
    rises = 0;
    @(posedge clk) {plug, pch, pcat} <= {1'b1, c, k};
    @(posedge clk) plug <= 1'b0;
    for (int n = 0; n < 300 && !cv; n++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk(16'(hi), sl ? 16'h0000 : boost ? 16'(3 * HALF) : 16'(STD));
    chk(16'(rises), sl ? 16'h0000 : boost ? 16'h0003 : 16'h0001);
  endtask

  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #500000;
    miscompares++;
    conclude();
  end

  initial begin
    void'($urandom(17));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    br(A_CTRL, {8'h00, CTRL_RST});
    br(A_BUDGET, BUDGET_RST);
    bw(8'h08, 16'h1234);
    br(8'h08, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      pd(i[3:0], i[2:0]);
      used += allow(i[2:0]);
      chk(16'(pwr[i]), 16'h0001);
    end
    br(A_USED, used);
    $display("test admission done");
    ch = 4'($urandom_range(11));
    r = 16'($urandom);
    @(posedge clk) {av, ach, ak, ad} <= {1'b1, ch, K_CUR, r[14:0]};
    @(posedge clk) {ak, ad} <= {K_VOLT, ~r[14:0]};
    @(posedge clk) {av, sv, sch, scond, sres} <= {1'b0, 1'b1, ch, r[9:0], 16'hEA60};
    @(posedge clk) sv <= 1'b0;
    br({R_IMON, ch}, {1'b0, r[14:0]});
    br({R_VMEAS, ch}, {4'h0, ~r[11:0]});
    br({R_SIG, ch}, {6'h00, r[9:0]});
    br(A_OPEN, 16'(1 << ch));
    bw(A_CTRL, 16'h00E1);
    @(posedge clk) {sv, sres} <= {1'b1, RES_BASE + {4'h0, r[11:0]}};
    @(posedge clk) sv <= 1'b0;
    br({R_SIG, ch}, {4'h0, r[11:0]});
    $display("test measurements done");
    @(posedge clk) {flt[2], ovx[3], pov[3]} <= 3'b111;
    repeat (3) @(posedge clk);
    chk(16'(pwr[3:2]), 16'h0000);
    @(posedge clk) {flt, ovx, pov} <= '0;
    br(A_ALARM, 16'h000C);
    br(A_USED, used - allow(3'h2) - allow(3'h3));
    tmp(T_WARN);
    chk(16'(therm), 16'h0001);
    pd(4'h6, 3'h1);
    chk(16'(pwr[6]), 16'h0000);
    tmp(T_REL);
    chk(16'(pwr[6]), 16'h0001);
    @(posedge clk) ilim[0] <= 1'b1;
    tmp(T_HOT);
    chk({12'h000, therm, pwr[1:0]}, 16'h000E);
    tmp(T_CRIT);
    chk({2'b00, therm, pwr}, 16'h2000);
    @(posedge clk) ilim[0] <= 1'b0;
    tmp(8'h65);
    chk(16'(therm), 16'h0002);
    tmp(T_REL);
    $display("test thermal done");
    bw(A_ALARM, 16'h0FFF);
    bw(A_BUDGET, ALLOW_C1);
    bw(A_CTRL, 16'h0083);
    pd(4'h0, 3'h1);
    pd(4'h1, 3'h2);
    chk(16'(pwr[1:0]), 16'h0001);
    br(A_ALARM, 16'h0002);
    bw(A_CTRL, 16'h00C3);
    pd(4'h2, 3'h2);
    chk(16'(pwr[2]), 16'h0000);
    bw({R_PRIO, 4'h4}, 16'h0003);
    pd(4'h4, 3'h1);
    bw(A_BUDGET, ALLOW_C1 + ALLOW_C1 + ALLOW_C2);
    repeat (2) @(posedge clk);
    chk({14'h0, pwr[4], pwr[2]}, 16'h0002);
    @(posedge clk);
    chk(16'(pwr[2]), 16'h0001);
    @(posedge clk) {ce, a, wd, we} <= {1'b0, A_BUDGET, 16'h0001, 1'b1};
    @(posedge clk) {ce, we} <= 2'b10;
    br(A_BUDGET, ALLOW_C1 + ALLOW_C1 + ALLOW_C2);
    $display("test smart power done");
    bw(A_CTRL, 16'h0085);
    boost = 1'b1;
    pd(4'h3, CAT_BOOST);
    chk({14'h0, pwr[7], pwr[3]}, 16'h0003);
    pd(4'h1, CAT_STD_MAX);
    chk({14'h0, pwr[5], pwr[1]}, 16'h0001);
    br(A_PWR, 16'h001F);
    pd(4'h5, 3'h1);
    chk(16'(pwr[5]), 16'h0000);
    @(posedge clk) flt[7] <= 1'b1;
    repeat (2) @(posedge clk);
    chk({14'h0, pwr[7], pwr[3]}, 16'h0000);
    @(posedge clk) flt[7] <= 1'b0;
    bw(A_CTRL, 16'h0000);
    bw(A_MANUAL, 16'h0800);
    @(posedge clk);
    chk(16'(pwr[11]), 16'h0001);
    $display("test boost and manual done");
    conclude();
  end
endmodule
